// *** bench/bcx_chk_assertions.sv ***
// Checker for the execution core ports
`default_nettype none
module bcx_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Watched ports
  input wire logic [13:0] instr_word,
  input wire logic fetch,
  input wire logic [10:0] pc,
  input wire logic [6:0] rf_addr,
  input wire logic rf_rd,
  input wire logic [7:0] rf_rdata,
  input wire logic rf_wr,
  input wire logic [7:0] rf_wdata,
  input wire logic [7:0] acc,
  input wire logic null_result_flag,
  input wire logic [1:0] q_phase,
  input wire logic flush
);
  logic [13:0] cur_w;
  logic [7:0] rd_val;
  logic [10:0] jt;
  wire xl = fetch && instr_word[13:8] == 6'h3a;
  wire jp = fetch && instr_word[13:11] == 3'h5;
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n) cur_w <= 14'h0000;
    else if (fetch) cur_w <= instr_word;
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n) rd_val <= 8'h00;
    else if (rf_rd) rd_val <= rf_rdata;
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n) jt <= 11'h000;
    else if (jp) jt <= instr_word[10:0];
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_cycle_four: assert property (fetch |=> !fetch [*3] ##1 fetch) else $error("cycle length");
  a_read_first: assert property (rf_wr |-> $past(rf_rd, 2) || $past(rf_rd, 3)) else $error("no read");
  a_read_slot: assert property (rf_rd |-> rf_addr == cur_w[6:0]) else $error("slot");
  a_xor_w_literal_op_acc: assert property (xl ##1 !flush |-> ##3 acc == ($past(acc, 4) ^ $past(instr_word[7:0], 4)))
    else $error("xor_w_literal_op");
  a_xor_w_literal_op_zero: assert property (xl ##1 !flush |-> ##3 null_result_flag == (acc == 8'h00))
    else $error("zero");
  a_flush_jump: assert property (jp ##1 !flush |-> ##4 flush [*4]) else $error("flush");
  a_phase_order: assert property (fetch |-> q_phase == 2'h2 ##1 q_phase == 2'h3 ##1 q_phase == 2'h0)
    else $error("phase");
  a_swap_flag: assert property (fetch && instr_word[13:8] == 6'h0e |-> ##4
    null_result_flag == $past(null_result_flag, 4)) else $error("swap flag");
  a_swap_data: assert property (rf_wr && cur_w[13:8] == 6'h0e |->
    rf_wdata == {rd_val[3:0], rd_val[7:4]} && rf_addr == cur_w[6:0]) else $error("swap");
  a_target_acc: assert property (fetch && instr_word[13:7] inside {7'h0c, 7'h1c} |=> !rf_wr [*4])
    else $error("target");
  a_jump_load: assert property (jp |-> ##[1:8] (fetch && pc == jt)) else $error("jump");
  c_xor_w_literal_op: cover property (xl);
  c_write: cover property (rf_wr);
  c_jump: cover property (jp);
endmodule
bind bcx_core bcx_chk u_chk (.*);
`default_nettype wire

// *** bench/bcx_mem.sv ***
// Program memory and register file model
`default_nettype none
module bcx_mem (
  // Clock
  input wire logic clk,
  // Program side
  input wire logic [10:0] pc,
  output logic [13:0] instr_word,
  // Register file side
  input wire logic [6:0] rf_addr,
  input wire logic rf_rd,
  input wire logic rf_wr,
  input wire logic [7:0] rf_wdata,
  output logic [7:0] rf_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [13:0] prog [0:2047];
  logic [7:0] rf [0:127];
  int rd_cnt = 0;
  initial foreach (prog[i]) prog[i] = 14'h0000;
  assign instr_word = prog[pc];
  assign rf_rdata = rf[rf_addr];
  always @(posedge clk)
  begin
    if (rf_rd) rd_cnt <= rd_cnt + 1;
    if (rf_wr) rf[rf_addr] <= rf_wdata;
  end
endmodule
`default_nettype wire

// *** bench/tb_byte_core_exec_subset.sv ***
// Self-checking testbench for the execution core
`default_nettype none
module tb_byte_core_exec_subset;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  wire [13:0] instr_word;
  wire [10:0] pc;
  wire [6:0] rf_addr;
  wire [7:0] rf_rdata, rf_wdata, acc;
  wire fetch, rf_rd, rf_wr, null_result_flag, flush;
  int err_total = 0;
  int n_tests = 0;
  always #50 clk = ~clk;
  bcx_core DUT (.q_phase(), .*);
  bcx_mem u_mem (.*);
  // ==========================================
  // Helpers
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic clr;
    for (int i = 0; i < 16; i++) u_mem.prog[i] = 14'h0000;
  endtask
  task automatic run(int n);
    @(posedge clk);
    #5 arst_n = 1'b0;
    repeat (2) @(posedge clk);
    #5 arst_n = 1'b1;
    repeat (4 * n + 12) @(posedge clk);
    #5;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_xor_lit;
    clr;
    u_mem.prog[0] = {6'h3a, 8'ha5};
    run(1);
    check(acc, 8'ha5);
    check(null_result_flag, 8'h00);
    u_mem.prog[1] = {6'h3a, 8'ha5};
    run(2);
    check(acc, 8'h00);
    check(null_result_flag, 8'h01);
    $display("done xor literal");
  endtask
  task automatic t_xor_file;
    clr;
    u_mem.rf[16] = 8'h3c;
    u_mem.prog[0] = {6'h3a, 8'ha5};
    u_mem.prog[1] = {6'h06, 1'b1, 7'h10};
    u_mem.prog[2] = {6'h06, 1'b0, 7'h10};
    run(3);
    check(u_mem.rf[16], 8'h99);
    check(acc, 8'h3c);
    check(null_result_flag, 8'h00);
    $display("done xor file");
  endtask
  task automatic t_swap;
    clr;
    u_mem.rf[127] = 8'h12;
    u_mem.prog[0] = {6'h3a, 8'ha5};
    u_mem.prog[1] = {6'h3a, 8'ha5};
    u_mem.prog[2] = {6'h0e, 1'b0, 7'h7f};
    u_mem.prog[3] = {6'h0e, 1'b1, 7'h7f};
    run(4);
    check(acc, 8'h21);
    check(null_result_flag, 8'h01);
    check(u_mem.rf[127], 8'h21);
    $display("done swap");
  endtask
  task automatic t_clear;
    clr;
    u_mem.rf[32] = 8'h77;
    u_mem.prog[0] = {6'h01, 1'b1, 7'h20};
    u_mem.rd_cnt = 0;
    run(1);
    check(u_mem.rf[32], 8'h00);
    check(u_mem.rd_cnt[7:0], 8'h01);
    $display("done clear");
  endtask
  task automatic t_jump;
    clr;
    u_mem.rf[127] = 8'h12;
    u_mem.prog[0] = {3'h5, 11'h00a};
    u_mem.prog[1] = {6'h0e, 1'b0, 7'h7f};
    u_mem.prog[10] = {6'h3a, 8'h0f};
    run(5);
    check(acc, 8'h0f);
    $display("done jump");
  endtask
  task automatic t_skip;
    clr;
    u_mem.rf[5] = 8'h04;
    u_mem.prog[0] = {2'h1, 2'h3, 3'h2, 7'h05};
    u_mem.prog[1] = {6'h3a, 8'h11};
    u_mem.prog[2] = {6'h3a, 8'h22};
    u_mem.prog[3] = {2'h1, 2'h3, 3'h0, 7'h05};
    u_mem.prog[4] = {6'h3a, 8'h22};
    run(5);
    check(acc, 8'h00);
    check(null_result_flag, 8'h01);
    check(u_mem.rf[5], 8'h04);
    $display("done bit skip");
  endtask
  // ==========================================
  // Verdict and main sequence
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #200000;
    err_total++;
    wrap_up;
  end
  initial
  begin
    t_xor_lit;
    t_xor_file;
    t_swap;
    t_clear;
    t_jump;
    t_skip;
    wrap_up;
  end
endmodule
`default_nettype wire

// *** pkg/bcx_pkg.sv ***
// Package of constants and types for the byte core execution subset
`default_nettype none
package bcx_pkg;
  // ==========================================
  // Instruction word layout
  localparam int WORD_W = 14;
  localparam int DATA_W = 8;
  localparam int SLOT_W = 7;
  localparam int POS_W = 3;
  localparam int LIT8_W = 8;
  localparam int LIT11_W = 11;
  localparam int TGT_BIT = 7;
  localparam int POS_LSB = 7;
  localparam int OP6_LSB = 8;
  // ==========================================
  // Opcodes (upper six bits for byte ops, upper bits for literal ops)
  localparam logic [5:0] OP_SWAP = 6'h0e;
  localparam logic [5:0] OP_XOR_W_FILE_OP = 6'h06;
  localparam logic [5:0] OP_CLRF = 6'h01;
  localparam logic [5:0] OP_XOR_W_LITERAL_OP = 6'h3a;
  localparam logic [2:0] OP_GOTO = 3'h5;
  localparam logic [1:0] OP_BITTEST = 2'h1;
  localparam logic [13:0] NOP_WORD = 14'h0000;
  // ==========================================
  // Timing
  localparam int CLK_PER_CYCLE = 4;
  localparam logic [1:0] Q_LAST = 2'h3;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  // ==========================================
  // Operation class
  typedef enum logic [2:0] {BCX_NOP, BCX_SWAP, BCX_XOR_W_FILE_OP, BCX_CLRF, BCX_XOR_W_LITERAL_OP, BCX_JUMP, BCX_SKIPT} bcx_op_t;
endpackage
`default_nettype wire

// *** rtl/bcx_core.sv ***
// Execution core for the swap, exclusive-OR and clear subset
`default_nettype none
module bcx_core (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Program memory
  input wire logic [13:0] instr_word,
  output logic fetch,
  output logic [10:0] pc,
  // Register file
  output logic [6:0] rf_addr,
  output logic rf_rd,
  input wire logic [7:0] rf_rdata,
  output logic rf_wr,
  output logic [7:0] rf_wdata,
  // Core state
  output logic [7:0] acc,
  output logic null_result_flag,
  output logic [1:0] q_phase,
  output logic flush
);
  // ==========================================
  // Reset release
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end
  // ==========================================
  // Phase and decode
  logic [1:0] q;
  logic cyc_end;
  bcx_phase u_phase (
    .clk(clk),
    .rst_n(rst_n),
    .q(q),
    .cyc_end(cyc_end)
  );
  logic [13:0] ir;
  logic [13:0] word_s;
  bcx_pkg::bcx_op_t op;
  logic [6:0] slot;
  logic tgt;
  logic [2:0] pos;
  logic [7:0] lit8;
  logic [10:0] lit11;
  assign word_s = flush ? bcx_pkg::NOP_WORD : ir;
  bcx_decode u_dec (
    .word(word_s),
    .op(op),
    .slot(slot),
    .tgt(tgt),
    .pos(pos),
    .lit8(lit8),
    .lit11(lit11)
  );
  // ==========================================
  // Instruction latch at cycle start
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ir <= bcx_pkg::NOP_WORD;
    end
    else if (cyc_end)
    begin
      ir <= instr_word;
    end
  end
  // ==========================================
  // Operand read and result
  logic [7:0] opnd;
  logic [7:0] result;
  logic uses_file;
  logic zero_upd;
  logic to_reg;
  logic bit_true;
  assign uses_file = (op == bcx_pkg::BCX_SWAP) || (op == bcx_pkg::BCX_XOR_W_FILE_OP) ||
                     (op == bcx_pkg::BCX_CLRF) || (op == bcx_pkg::BCX_SKIPT);
  assign bit_true = opnd[pos];
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      opnd <= 8'h00;
    end
    else if (q == 2'h1)
    begin
      opnd <= rf_rdata;
    end
  end
  always_comb
  begin
    result = 8'h00;
    zero_upd = 1'b0;
    to_reg = 1'b0;
    unique case (op)
      bcx_pkg::BCX_SWAP:
      begin
        result = {opnd[3:0], opnd[7:4]};
        to_reg = tgt;
      end
      bcx_pkg::BCX_XOR_W_FILE_OP:
      begin
        result = acc ^ opnd;
        to_reg = tgt;
        zero_upd = 1'b1;
      end
      bcx_pkg::BCX_CLRF:
      begin
        result = 8'h00;
        to_reg = 1'b1;
        zero_upd = 1'b1;
      end
      bcx_pkg::BCX_XOR_W_LITERAL_OP:
      begin
        result = acc ^ lit8;
        zero_upd = 1'b1;
      end
      bcx_pkg::BCX_NOP, bcx_pkg::BCX_JUMP, bcx_pkg::BCX_SKIPT:
      begin
        result = 8'h00;
      end
    endcase
  end
  // ==========================================
  // Write enables
  logic acc_we;
  logic file_we;
  logic result_zero;
  assign result_zero = (result == 8'h00);
  always_comb
  begin
    acc_we = 1'b0;
    file_we = 1'b0;
    if (q == 2'h2)
    begin
      acc_we = !to_reg && (op == bcx_pkg::BCX_SWAP || op == bcx_pkg::BCX_XOR_W_FILE_OP ||
               op == bcx_pkg::BCX_XOR_W_LITERAL_OP);
      file_we = uses_file && to_reg && (op != bcx_pkg::BCX_SKIPT);
    end
  end
  // ==========================================
  // Next program counter
  logic [10:0] next_pc;
  logic next_flush;
  always_comb
  begin
    next_pc = pc + 11'h001;
    next_flush = 1'b0;
    unique case (op)
      bcx_pkg::BCX_JUMP:
      begin
        next_pc = lit11;
        next_flush = 1'b1;
      end
      bcx_pkg::BCX_SKIPT:
      begin
        next_flush = bit_true;
      end
      bcx_pkg::BCX_NOP, bcx_pkg::BCX_SWAP, bcx_pkg::BCX_XOR_W_FILE_OP, bcx_pkg::BCX_CLRF, bcx_pkg::BCX_XOR_W_LITERAL_OP:
      begin
        next_flush = 1'b0;
      end
    endcase
  end
  // ==========================================
  // Register file strobes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rf_addr <= 7'h00;
    end
    else
    begin
      rf_addr <= slot;
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rf_rd <= 1'b0;
    end
    else
    begin
      rf_rd <= (q == 2'h0) && uses_file;
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rf_wr <= 1'b0;
    end
    else
    begin
      rf_wr <= file_we;
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rf_wdata <= 8'h00;
    end
    else
    begin
      rf_wdata <= result;
    end
  end
  // ==========================================
  // Accumulator and zero flag
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc <= bcx_pkg::ACC_RESET;
    end
    else if (acc_we)
    begin
      acc <= result;
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      null_result_flag <= 1'b0;
    end
    else if (q == 2'h2 && zero_upd)
    begin
      null_result_flag <= result_zero;
    end
  end
  // ==========================================
  // Program counter and flush
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc <= 11'h000;
    end
    else if (cyc_end)
    begin
      pc <= next_pc;
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flush <= 1'b0;
    end
    else if (cyc_end)
    begin
      flush <= next_flush;
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fetch <= 1'b0;
    end
    else
    begin
      fetch <= (q == 2'h2);
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q_phase <= 2'h0;
    end
    else
    begin
      q_phase <= q;
    end
  end
endmodule
`default_nettype wire

// *** rtl/bcx_decode.sv ***
// Instruction word field decoder
`default_nettype none
module bcx_decode (
  // Instruction word
  input wire logic [13:0] word,
  // Fields
  output bcx_pkg::bcx_op_t op,
  output logic [6:0] slot,
  output logic tgt,
  output logic [2:0] pos,
  output logic [7:0] lit8,
  output logic [10:0] lit11
);
  // ==========================================
  // Field split
  assign slot = word[bcx_pkg::SLOT_W-1:0];
  assign tgt = word[bcx_pkg::TGT_BIT];
  assign pos = word[bcx_pkg::POS_LSB +: bcx_pkg::POS_W];
  assign lit8 = word[bcx_pkg::LIT8_W-1:0];
  assign lit11 = word[bcx_pkg::LIT11_W-1:0];
  // ==========================================
  // Opcode class
  always_comb
  begin
    op = bcx_pkg::BCX_NOP;
    if (word[13:8] == bcx_pkg::OP_SWAP)
      op = bcx_pkg::BCX_SWAP;
    else if (word[13:8] == bcx_pkg::OP_XOR_W_FILE_OP)
      op = bcx_pkg::BCX_XOR_W_FILE_OP;
    else if (word[13:8] == bcx_pkg::OP_CLRF && word[7])
      op = bcx_pkg::BCX_CLRF;
    else if (word[13:8] == bcx_pkg::OP_XOR_W_LITERAL_OP)
      op = bcx_pkg::BCX_XOR_W_LITERAL_OP;
    else if (word[13:11] == bcx_pkg::OP_GOTO)
      op = bcx_pkg::BCX_JUMP;
    else if (word[13:12] == bcx_pkg::OP_BITTEST)
      op = bcx_pkg::BCX_SKIPT;
  end
endmodule
`default_nettype wire

// *** rtl/bcx_phase.sv ***
// Four-period instruction cycle phase generator
`default_nettype none
module bcx_phase (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Phase
  output logic [1:0] q,
  output logic cyc_end
);
  // ==========================================
  // Phase counter
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= 2'h0;
    end
    else
    begin
      q <= q + 2'h1;
    end
  end
  assign cyc_end = (q == bcx_pkg::Q_LAST);
endmodule
`default_nettype wire
